// ### design/crtc_pkg.sv
// Shared constants and types for the CRT display-end, offset and underline block
package crtc_pkg;

	// I/O port addresses of the indexed CRT register pair
	localparam logic [15:0] IO_MONO_INDEX = 16'h03B4;
	localparam logic [15:0] IO_MONO_DATA = 16'h03B5;
	localparam logic [15:0] IO_COLOR_INDEX = 16'h03D4;
	localparam logic [15:0] IO_COLOR_DATA = 16'h03D5;

	// Register indices
	localparam logic [7:0] IDX_VDISP_END_LOW = 8'h12;
	localparam logic [7:0] IDX_ROW_OFFSET = 8'h13;
	localparam logic [7:0] IDX_UNDERLINE_MODE = 8'h14;
	localparam logic [7:0] IDX_VBLANK_START_LOW = 8'h15;

	// Reset values of the held registers
	localparam logic [7:0] RST_INDEX = 8'h00;
	localparam logic [7:0] RST_VDISP_END_LOW = 8'h00;
	localparam logic [7:0] RST_ROW_OFFSET = 8'h00;
	localparam logic [6:0] RST_UNDERLINE_MODE = 7'h00;
	localparam logic [7:0] RST_VBLANK_START_LOW = 8'h00;

	// Field positions in underline_and_address_mode
	localparam int UL_DWORD_BIT = 6;
	localparam int UL_COUNT4_BIT = 5;
	localparam int UL_LOC_MSB = 4;
	localparam int UL_LOC_LSB = 0;

	// Field positions in vertical_overflow_bits
	localparam int OVF_VDE_BIT9 = 6;
	localparam int OVF_VDE_BIT8 = 1;

	// Field positions in crt_mode_control
	localparam int CMC_BYTE_MODE_BIT = 6;
	localparam int CMC_COUNT2_BIT = 3;

	// Field position in clocking_mode_control choosing doubleword pitch units
	localparam int CLK_PITCH_DWORD_BIT = 4;

	// Frame buffer addressing modes
	typedef enum logic [1:0] {
		MODE_BYTE = 2'h0,
		MODE_WORD = 2'h1,
		MODE_DWORD = 2'h2
	} addr_mode_t;

	// Counter advance interval as a power of two
	typedef enum logic [1:0] {
		EVERY_1 = 2'h0,
		EVERY_2 = 2'h1,
		EVERY_4 = 2'h2
	} interval_t;

	// Display region states, Gray coded
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ACTIVE = 2'b01,
		ST_BLANK = 2'b11
	} region_t;

endpackage

// ### design/crtc_mode_decode.sv
// Addressing mode, advance interval and pitch unit decode
module crtc_mode_decode (
	input wire logic dword_sel,
	input wire logic byte_sel,
	input wire logic count4_sel,
	input wire logic count2_sel,
	input wire logic pitch_dword_sel,
	output crtc_pkg::addr_mode_t addr_mode,
	output crtc_pkg::interval_t interval,
	output logic [1:0] pitch_shift
);

	always_comb begin
		if (dword_sel) begin
			addr_mode = crtc_pkg::MODE_DWORD;
		end else if (byte_sel) begin
			addr_mode = crtc_pkg::MODE_BYTE;
		end else begin
			addr_mode = crtc_pkg::MODE_WORD;
		end
		case ({count4_sel, count2_sel})
			2'b00: interval = crtc_pkg::EVERY_1;
			2'b10: interval = crtc_pkg::EVERY_4;
			default: interval = crtc_pkg::EVERY_2;
		endcase
		pitch_shift = pitch_dword_sel ? 2'h2 : 2'h1;
	end

endmodule // crtc_mode_decode

// ### design/crtc_advance_pacer.sv
// Paces memory address counter advances to 1, 2 or 4 character clocks
module crtc_advance_pacer (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic restart,
	input wire logic run,
	input wire crtc_pkg::interval_t interval,
	output logic tick
);

	logic [1:0] phase_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_ff <= 2'h0;
		end else if (restart || !run) begin
			phase_ff <= 2'h0;
		end else begin
			phase_ff <= phase_ff + 2'h1;
		end
	end

	always_comb begin
		case (interval)
			crtc_pkg::EVERY_1: tick = run;
			crtc_pkg::EVERY_2: tick = run && (phase_ff[0] == 1'b1);
			crtc_pkg::EVERY_4: tick = run && (phase_ff == 2'h3);
			default: tick = run;
		endcase
	end

endmodule // crtc_advance_pacer

// ### design/vga_crtc_display_end_offset_underline.sv
// CRT display-end count, row pitch and underline/address-mode registers with fetch addressing
//
// Contract
// - Display-end register is low eight of ten
// - Upper two bits from overflow bits 6,1
// - Offset register is the row address step
// - Offset counts words or doublewords per clocking
// - Underline register bit 7 reads zero
// - Doubleword, byte/word bits choose addressing mode
// - Count bits choose advance every 1/2/4
// - Text underline drawn on selected cell line
// - Cell lines numbered from top, zero first
module vga_crtc_display_end_offset_underline #(
	parameter int ADDR_W = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	input wire logic color_sel,
	output logic [7:0] io_rdata_ff,
	output logic io_rdata_valid_ff,
	input wire logic [7:0] vertical_overflow_bits,
	input wire logic [7:0] crt_mode_control,
	input wire logic [7:0] clocking_mode_control,
	input wire logic frame_start,
	input wire logic row_start,
	input wire logic [9:0] scan_line,
	input wire logic [4:0] cell_line,
	input wire logic text_mode,
	input wire logic [ADDR_W-1:0] start_address,
	output logic [9:0] display_end_count_ff,
	output logic display_active_ff,
	output logic last_line_ff,
	output logic underline_on_ff,
	output logic [ADDR_W+1:0] fetch_addr_ff,
	output logic fetch_strobe_ff,
	output logic [1:0] addr_mode_ff,
	output logic [7:0] row_offset_pitch_ff,
	output logic [7:0] vblank_start_low_ff
);

	// Fetch address is ADDR_W plus two shift bits and must stay within 32 bits
	if (ADDR_W < 10 || ADDR_W > 30) begin : g_addr_w_check
		$error("ADDR_W must lie between 10 and 30");
	end

	// Which held register an index selects
	function automatic logic [3:0] index_hit(input logic [7:0] idx);
		index_hit = {idx == crtc_pkg::IDX_VBLANK_START_LOW,
			idx == crtc_pkg::IDX_UNDERLINE_MODE,
			idx == crtc_pkg::IDX_ROW_OFFSET,
			idx == crtc_pkg::IDX_VDISP_END_LOW};
	endfunction

	logic [7:0] index_ff;
	logic [7:0] vdisp_end_low_ff;
	logic [6:0] underline_mode_ff;
	logic [ADDR_W-1:0] ma_ff;
	logic [ADDR_W-1:0] row_base_ff;
	crtc_pkg::region_t region_ff;
	crtc_pkg::region_t nxt_region;

	logic [15:0] index_port;
	logic [15:0] data_port;
	logic index_wr;
	logic data_wr;
	logic index_rd;
	logic data_rd;
	logic [3:0] wr_hit;
	logic [3:0] rd_hit;
	logic [9:0] end_count;
	logic [4:0] underline_loc;
	crtc_pkg::addr_mode_t addr_mode;
	crtc_pkg::interval_t interval;
	logic [1:0] pitch_shift;
	logic advance_tick;
	logic [ADDR_W-1:0] row_step;
	logic [ADDR_W-1:0] nxt_row_base;
	logic [ADDR_W+1:0] nxt_fetch_addr;
	logic in_display;
	logic pacer_run;
	logic pacer_restart;
	logic fetch_go;

	// Port decode, mono or color base
	always_comb begin
		index_port = color_sel ? crtc_pkg::IO_COLOR_INDEX : crtc_pkg::IO_MONO_INDEX;
		data_port = color_sel ? crtc_pkg::IO_COLOR_DATA : crtc_pkg::IO_MONO_DATA;
		index_wr = io_wr && (io_addr == index_port);
		data_wr = io_wr && (io_addr == data_port);
		index_rd = io_rd && (io_addr == index_port);
		data_rd = io_rd && (io_addr == data_port);
		wr_hit = data_wr ? index_hit(index_ff) : 4'h0;
		rd_hit = data_rd ? index_hit(index_ff) : 4'h0;
	end

	// Index register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			index_ff <= crtc_pkg::RST_INDEX;
		end else if (index_wr) begin
			index_ff <= io_wdata;
		end
	end

	// Display-end low byte
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vdisp_end_low_ff <= crtc_pkg::RST_VDISP_END_LOW;
		end else if (wr_hit[0]) begin
			vdisp_end_low_ff <= io_wdata;
		end
	end

	// Row offset pitch
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			row_offset_pitch_ff <= crtc_pkg::RST_ROW_OFFSET;
		end else if (wr_hit[1]) begin
			row_offset_pitch_ff <= io_wdata;
		end
	end

	// Underline and address mode, bit 7 not stored
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			underline_mode_ff <= crtc_pkg::RST_UNDERLINE_MODE;
		end else if (wr_hit[2]) begin
			underline_mode_ff <= io_wdata[6:0];
		end
	end

	// Vertical blank start low byte, held for the rest of the controller
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vblank_start_low_ff <= crtc_pkg::RST_VBLANK_START_LOW;
		end else if (wr_hit[3]) begin
			vblank_start_low_ff <= io_wdata;
		end
	end

	// Read port: answers the index port and the four held indices
	// Unmatched indices give no valid pulse, so the host sees no answer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			io_rdata_ff <= 8'h00;
			io_rdata_valid_ff <= 1'b0;
		end else begin
			io_rdata_valid_ff <= index_rd || (rd_hit != 4'h0);
			if (index_rd) begin
				io_rdata_ff <= index_ff;
			end else if (rd_hit[0]) begin
				io_rdata_ff <= vdisp_end_low_ff;
			end else if (rd_hit[1]) begin
				io_rdata_ff <= row_offset_pitch_ff;
			end else if (rd_hit[2]) begin
				io_rdata_ff <= {1'b0, underline_mode_ff};
			end else if (rd_hit[3]) begin
				io_rdata_ff <= vblank_start_low_ff;
			end else begin
				io_rdata_ff <= 8'h00;
			end
		end
	end

	// Ten-bit last active line; software loads lines minus one
	always_comb begin
		end_count = {vertical_overflow_bits[crtc_pkg::OVF_VDE_BIT9],
			vertical_overflow_bits[crtc_pkg::OVF_VDE_BIT8],
			vdisp_end_low_ff};
		underline_loc = underline_mode_ff[crtc_pkg::UL_LOC_MSB:crtc_pkg::UL_LOC_LSB];
		in_display = scan_line <= end_count;
		pacer_run = (region_ff == crtc_pkg::ST_ACTIVE) && in_display;
		pacer_restart = frame_start || row_start;
	end

	crtc_mode_decode u_mode_decode (
		.dword_sel(underline_mode_ff[crtc_pkg::UL_DWORD_BIT]),
		.byte_sel(crt_mode_control[crtc_pkg::CMC_BYTE_MODE_BIT]),
		.count4_sel(underline_mode_ff[crtc_pkg::UL_COUNT4_BIT]),
		.count2_sel(crt_mode_control[crtc_pkg::CMC_COUNT2_BIT]),
		.pitch_dword_sel(clocking_mode_control[crtc_pkg::CLK_PITCH_DWORD_BIT]),
		.addr_mode(addr_mode),
		.interval(interval),
		.pitch_shift(pitch_shift)
	);

	// Display region tracking
	always_comb begin
		case (region_ff)
			crtc_pkg::ST_IDLE: begin
				nxt_region = frame_start ? crtc_pkg::ST_ACTIVE : crtc_pkg::ST_IDLE;
			end
			crtc_pkg::ST_ACTIVE: begin
				if (frame_start) begin
					nxt_region = crtc_pkg::ST_ACTIVE;
				end else if (row_start && !in_display) begin
					nxt_region = crtc_pkg::ST_BLANK;
				end else begin
					nxt_region = crtc_pkg::ST_ACTIVE;
				end
			end
			crtc_pkg::ST_BLANK: begin
				nxt_region = frame_start ? crtc_pkg::ST_ACTIVE : crtc_pkg::ST_BLANK;
			end
			default: nxt_region = crtc_pkg::ST_IDLE;
		endcase
	end

	// Leaving active waits for a row boundary so a row is never cut
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			region_ff <= crtc_pkg::ST_IDLE;
		end else begin
			region_ff <= nxt_region;
		end
	end

	// Counter runs only inside the active lines of a started frame
	crtc_advance_pacer u_pacer (
		.clk(clk),
		.rst_n(rst_n),
		.restart(pacer_restart),
		.run(pacer_run),
		.interval(interval),
		.tick(advance_tick)
	);

	// Row step and shifted fetch address
	always_comb begin
		row_step = ADDR_W'({row_offset_pitch_ff, 2'b00} >> (2'h2 - pitch_shift));
		nxt_row_base = row_base_ff + row_step;
		// A restart reloads the counter, so its cycle issues no fetch
		fetch_go = advance_tick && !pacer_restart;
		case (addr_mode)
			crtc_pkg::MODE_BYTE: nxt_fetch_addr = {2'b00, ma_ff};
			crtc_pkg::MODE_WORD: nxt_fetch_addr = {1'b0, ma_ff, 1'b0};
			crtc_pkg::MODE_DWORD: nxt_fetch_addr = {ma_ff, 2'b00};
			default: nxt_fetch_addr = {2'b00, ma_ff};
		endcase
	end

	// Memory address counter and row base
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ma_ff <= '0;
			row_base_ff <= '0;
		end else if (frame_start) begin
			ma_ff <= start_address;
			row_base_ff <= start_address;
		end else if (row_start) begin
			ma_ff <= nxt_row_base;
			row_base_ff <= nxt_row_base;
		end else if (advance_tick) begin
			ma_ff <= ma_ff + ADDR_W'(1);
		end
	end

	// Fetch request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fetch_addr_ff <= '0;
			fetch_strobe_ff <= 1'b0;
		end else begin
			fetch_strobe_ff <= fetch_go;
			if (fetch_go) begin
				fetch_addr_ff <= nxt_fetch_addr;
			end
		end
	end

	// Status outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			display_end_count_ff <= 10'h000;
			display_active_ff <= 1'b0;
			last_line_ff <= 1'b0;
			addr_mode_ff <= 2'h0;
		end else begin
			display_end_count_ff <= end_count;
			display_active_ff <= (nxt_region == crtc_pkg::ST_ACTIVE) && in_display;
			last_line_ff <= (region_ff == crtc_pkg::ST_ACTIVE) && (scan_line == end_count);
			addr_mode_ff <= addr_mode;
		end
	end

	// Underline on the chosen cell line, line 0 at top
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			underline_on_ff <= 1'b0;
		end else begin
			underline_on_ff <= text_mode && (cell_line == underline_loc);
		end
	end

endmodule // vga_crtc_display_end_offset_underline

// ### testbench/crtc_monitor.sv
// Checker for the CRT display-end, pitch and underline block ports
module crtc_monitor (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	input wire logic color_sel,
	input wire logic [7:0] io_rdata_ff,
	input wire logic io_rdata_valid_ff,
	input wire logic [7:0] vertical_overflow_bits,
	input wire logic [7:0] crt_mode_control,
	input wire logic frame_start,
	input wire logic row_start,
	input wire logic [4:0] cell_line,
	input wire logic text_mode,
	input wire logic [9:0] display_end_count_ff,
	input wire logic display_active_ff,
	input wire logic last_line_ff,
	input wire logic underline_on_ff,
	input wire logic fetch_strobe_ff,
	input wire logic [1:0] addr_mode_ff,
	input wire logic [7:0] row_offset_pitch_ff
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [7:0] idx_ff;
	logic [7:0] vde_ff;
	logic [7:0] ul_ff;
	logic dsel;
	logic isel;
	logic [9:0] end_next;
	logic ul_hit;
	logic four;
	logic [1:0] mode_exp;
	assign dsel = io_addr == (color_sel ? crtc_pkg::IO_COLOR_DATA : crtc_pkg::IO_MONO_DATA);
	assign isel = io_addr == (color_sel ? crtc_pkg::IO_COLOR_INDEX : crtc_pkg::IO_MONO_INDEX);
	assign end_next = {vertical_overflow_bits[6], vertical_overflow_bits[1], vde_ff};
	assign ul_hit = text_mode && cell_line == ul_ff[4:0];
	assign four = ul_ff[5] && !crt_mode_control[3];
	assign mode_exp = ul_ff[6] ? 2'h2 : {1'b0, !crt_mode_control[6]};
	// Mirror of the index, display-end low and underline registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idx_ff <= 8'h00;
			vde_ff <= 8'h00;
			ul_ff <= 8'h00;
		end else if (io_wr && isel) begin
			idx_ff <= io_wdata;
		end else if (io_wr && dsel && idx_ff == crtc_pkg::IDX_VDISP_END_LOW) begin
			vde_ff <= io_wdata;
		end else if (io_wr && dsel && idx_ff == crtc_pkg::IDX_UNDERLINE_MODE) begin
			ul_ff <= {1'b0, io_wdata[6:0]};
		end
	end
	a_end_count:
		assert property ($past(rst_n) |-> display_end_count_ff == $past(end_next))
		else $error("display end count wrong");
	a_bit7_zero:
		assert property (io_rd && dsel && idx_ff == crtc_pkg::IDX_UNDERLINE_MODE
			|=> io_rdata_valid_ff && io_rdata_ff == $past(ul_ff))
		else $error("underline register read wrong");
	a_pitch_read:
		assert property (io_rd && dsel && idx_ff == crtc_pkg::IDX_ROW_OFFSET
			|=> io_rdata_valid_ff && io_rdata_ff == $past(row_offset_pitch_ff))
		else $error("pitch register read wrong");
	a_mode_select:
		assert property ($stable(mode_exp) [*3] |-> addr_mode_ff == mode_exp)
		else $error("addressing mode wrong");
	a_underline_line:
		assert property ($past(rst_n) |-> underline_on_ff == $past(ul_hit))
		else $error("underline line wrong");
	a_no_restart_fetch:
		assert property (frame_start || row_start |=> !fetch_strobe_ff)
		else $error("fetch at restart");
	a_every_four:
		assert property (fetch_strobe_ff && four && $past(four, 4) |=> (!fetch_strobe_ff) [*3])
		else $error("advance faster than every four");
	a_last_active:
		assert property (last_line_ff |-> display_active_ff)
		else $error("last line outside display");
endmodule // crtc_monitor

// ### testbench/crtc_host.sv
// Host model making indexed register accesses
module crtc_host (
	input wire logic clk,
	input wire logic color_sel,
	input wire logic [7:0] io_rdata_ff,
	input wire logic io_rdata_valid_ff,
	output logic [15:0] io_addr,
	output logic io_wr,
	output logic io_rd,
	output logic [7:0] io_wdata
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		io_addr = 16'h0000;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 8'h00;
	end
	// Index write, then data write or read; r holds valid and read data
	task automatic acc(input logic [7:0] idx, input logic wr, input logic [7:0] d, output logic [8:0] r);
		@(posedge clk);
		#1;
		io_addr = color_sel ? crtc_pkg::IO_COLOR_INDEX : crtc_pkg::IO_MONO_INDEX;
		io_wdata = idx;
		io_wr = 1'b1;
		@(posedge clk);
		#1;
		io_addr = color_sel ? crtc_pkg::IO_COLOR_DATA : crtc_pkg::IO_MONO_DATA;
		io_wdata = d;
		io_wr = wr;
		io_rd = !wr;
		@(posedge clk);
		#1;
		r = {io_rdata_valid_ff, io_rdata_ff};
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = ~d;
	endtask
endmodule // crtc_host

// ### testbench/testbench.sv
// Self-checking bench for the CRT display-end, pitch and underline block
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] io_addr;
	logic io_wr;
	logic io_rd;
	logic [7:0] io_wdata;
	logic color_sel = 1'b1;
	logic [7:0] io_rdata_ff;
	logic io_rdata_valid_ff;
	logic [7:0] vertical_overflow_bits = 8'h02;
	logic [7:0] crt_mode_control = 8'h00;
	logic [7:0] clocking_mode_control = 8'h00;
	logic frame_start = 1'b0;
	logic row_start = 1'b0;
	logic [9:0] scan_line = 10'h000;
	logic [4:0] cell_line = 5'h00;
	logic text_mode = 1'b0;
	logic [15:0] start_address = 16'h0064;
	logic [9:0] display_end_count_ff;
	logic display_active_ff;
	logic last_line_ff;
	logic underline_on_ff;
	logic [17:0] fetch_addr_ff;
	logic fetch_strobe_ff;
	logic [1:0] addr_mode_ff;
	logic [7:0] row_offset_pitch_ff;
	logic [7:0] vblank_start_low_ff;
	logic [8:0] r;
	logic [17:0] n;
	int miscompares = 0;
	int checked = 0;
	int cycles = 0;
	always #2.5 clk = ~clk;
	crtc_host host (.clk, .color_sel, .io_rdata_ff, .io_rdata_valid_ff, .io_addr, .io_wr, .io_rd, .io_wdata);
	vga_crtc_display_end_offset_underline dut (.clk, .rst_n, .io_addr, .io_wr, .io_rd, .io_wdata, .color_sel,
		.io_rdata_ff, .io_rdata_valid_ff, .vertical_overflow_bits, .crt_mode_control, .clocking_mode_control,
		.frame_start, .row_start, .scan_line, .cell_line, .text_mode, .start_address, .display_end_count_ff,
		.display_active_ff, .last_line_ff, .underline_on_ff, .fetch_addr_ff, .fetch_strobe_ff, .addr_mode_ff,
		.row_offset_pitch_ff, .vblank_start_low_ff);
	task automatic complete_run();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
		checked++;
		if (exp !== got) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic pulse(input logic row);
		tick(1);
		row_start = row;
		frame_start = !row;
		tick(1);
		row_start = 1'b0;
		frame_start = 1'b0;
	endtask
	// Write through colour ports, read back through mono ports
	task automatic t_regs();
		logic [7:0] idx [5] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h16};
		logic [7:0] wd [5] = '{8'hDF, 8'h05, 8'hFF, 8'hC3, 8'h77};
		logic [8:0] ex [5] = '{9'h1DF, 9'h105, 9'h17F, 9'h1C3, 9'h000};
		for (int i = 0; i < 5; i++) host.acc(idx[i], 1'b1, wd[i], r);
		color_sel = 1'b0;
		for (int i = 0; i < 5; i++) begin
			host.acc(idx[i], 1'b0, 8'h00, r);
			chk("read", {9'h0, ex[i]}, {9'h0, r & {1'b1, {8{ex[i][8]}}}});
		end
		color_sel = 1'b1;
	endtask
	// 480 active lines programmed as 479
	task automatic t_end();
		tick(2);
		chk("end", 18'h001DF, {8'h00, display_end_count_ff});
		vertical_overflow_bits = 8'h40;
		tick(2);
		chk("end", 18'h002DF, {8'h00, display_end_count_ff});
		vertical_overflow_bits = 8'h02;
	endtask
	task automatic t_mode();
		for (int i = 0; i < 4; i++) begin
			host.acc(crtc_pkg::IDX_UNDERLINE_MODE, 1'b1, {1'b0, i[1], 6'h00}, r);
			crt_mode_control = {1'b0, i[0], 6'h00};
			tick(2);
			chk("mode", i[1] ? 18'h00002 : {17'h0, !i[0]}, {16'h0, addr_mode_ff});
		end
	endtask
	task automatic t_pace();
		logic [17:0] ex [4] = '{18'h10, 18'h08, 18'h04, 18'h08};
		for (int i = 0; i < 4; i++) begin
			host.acc(crtc_pkg::IDX_UNDERLINE_MODE, 1'b1, {2'h0, i[1], 5'h00}, r);
			crt_mode_control = {4'h0, i[0], 3'h0};
			pulse(1'b0);
			n = 18'h0;
			repeat (16) begin
				tick(1);
				n = n + {17'h0, fetch_strobe_ff};
			end
			chk("advances", ex[i], n);
		end
	endtask
	task automatic t_pitch();
		logic [7:0] ul [3] = '{8'h00, 8'h00, 8'h40};
		logic [7:0] ck [3] = '{8'h00, 8'h10, 8'h00};
		logic [7:0] cm [3] = '{8'h40, 8'h40, 8'h00};
		logic [17:0] ex [3] = '{18'h0006E, 18'h00078, 18'h001B8};
		for (int i = 0; i < 3; i++) begin
			host.acc(crtc_pkg::IDX_UNDERLINE_MODE, 1'b1, ul[i], r);
			clocking_mode_control = ck[i];
			crt_mode_control = cm[i];
			pulse(1'b0);
			tick(2);
			pulse(1'b1);
			n = 18'h0;
			do begin
				tick(1);
				n++;
			end while (fetch_strobe_ff !== 1'b1 && n < 18'h8);
			chk("fetch", ex[i], fetch_addr_ff);
		end
	endtask
	// Last active line, then blanking after the next row start
	task automatic t_region();
		chk("vblank", 18'h000C3, {10'h000, vblank_start_low_ff});
		pulse(1'b0);
		scan_line = 10'h1DF;
		tick(2);
		chk("last", 18'h00003, {16'h0, last_line_ff, display_active_ff});
		scan_line = 10'h1E0;
		pulse(1'b1);
		tick(2);
		chk("blank", 18'h00000, {16'h0, last_line_ff, display_active_ff});
		n = 18'h0;
		repeat (8) begin
			tick(1);
			n = n + {17'h0, fetch_strobe_ff};
		end
		chk("blank fetches", 18'h00000, n);
		scan_line = 10'h000;
	endtask
	task automatic t_ul();
		host.acc(crtc_pkg::IDX_UNDERLINE_MODE, 1'b1, 8'h07, r);
		text_mode = 1'b1;
		for (int i = 6; i < 10; i++) begin
			text_mode = i < 9;
			cell_line = 5'h07 - 5'(i & 1);
			tick(2);
			chk("underline", {17'h0, i < 9 && i[0] == 1'b0}, {17'h0, underline_on_ff});
		end
		host.acc(crtc_pkg::IDX_UNDERLINE_MODE, 1'b1, 8'h00, r);
		text_mode = 1'b1;
		cell_line = 5'h00;
		tick(2);
		chk("underline", 18'h1, {17'h0, underline_on_ff});
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			complete_run();
		end
	end
	initial begin
		tick(6);
		rst_n = 1'b1;
		t_regs();
		t_end();
		t_mode();
		t_pace();
		t_pitch();
		t_region();
		t_ul();
		complete_run();
	end
endmodule // testbench
bind vga_crtc_display_end_offset_underline crtc_monitor mon (.clk, .rst_n, .io_addr, .io_wr, .io_rd, .io_wdata,
	.color_sel, .io_rdata_ff, .io_rdata_valid_ff, .vertical_overflow_bits, .crt_mode_control, .frame_start,
	.row_start, .cell_line, .text_mode, .display_end_count_ff, .display_active_ff, .last_line_ff,
	.underline_on_ff, .fetch_strobe_ff, .addr_mode_ff, .row_offset_pitch_ff);
